/* File: otc_cmp_slot.sv */
// constants package and the per-comparator trim register slot
`timescale 1ns/1ps
`default_nettype none

package otc_pkg;
  // register byte addresses on the wishbone bus
  localparam logic [7:0] OTC_CMP0_OFS = 8'h00; // comparator 0 offset trim
  localparam logic [7:0] OTC_CMP1_OFS = 8'h04; // comparator 1 offset trim
  localparam logic [7:0] OTC_HYST_OFS = 8'h08; // hysteresis window selects
  localparam logic [7:0] OTC_STAT_OFS = 8'h0c; // result bits and polarity selects
  localparam logic [7:0] OTC_AMP_OFS = 8'h10; // amplifier trim control
  // comparator trim register fields
  localparam int OTC_MODE_BIT = 6; // calibration mode select
  localparam int OTC_REF_BIT = 5; // calibration reference select
  localparam int OTC_TRIM_W = 5; // comparator trim width
  localparam logic [4:0] OTC_TRIM_RST = 5'h10; // trim reset value
  // hysteresis register fields
  localparam int OTC_HYS0_LSB = 0; // comparator 0 window
  localparam int OTC_HYS1_LSB = 2; // comparator 1 window
  localparam logic [3:0] OTC_HYST_RST = 4'h0; // hysteresis reset value
  // status register fields
  localparam int OTC_RES0_BIT = 0; // comparator 0 result
  localparam int OTC_RES1_BIT = 1; // comparator 1 result
  localparam int OTC_AOUT_BIT = 2; // amplifier output bit
  localparam int OTC_POL0_BIT = 4; // comparator 0 polarity select
  localparam int OTC_POL1_BIT = 5; // comparator 1 polarity select
  // amplifier register fields
  localparam int OTC_ATRIM_W = 6; // amplifier trim width
  localparam int OTC_AMODE_BIT = 6; // amplifier calibration mode
  localparam int OTC_AREF_BIT = 7; // amplifier reference select
  localparam logic [5:0] OTC_ATRIM_RST = 6'h20; // amplifier trim reset value
  // bus handshake states
  typedef enum logic [1:0] {
    OTC_IDLE = 2'b01, // waiting for a request
    OTC_ACK = 2'b10 // answer standing for one cycle
  } otc_wb_st_t;
endpackage : otc_pkg

module otc_cmp_slot
  import otc_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic wr_i, // one-cycle write strobe
  input wire logic [7:0] wdat_i, // write byte
  output logic mode_o, // calibration mode select
  output logic ref_o, // calibration reference select
  output logic [4:0] trim_o, // offset trim code
  output logic [7:0] rdat_o // read byte, bit 7 zero
);
  // fields load together on a write; bit 7 has no storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_o <= 1'b0; // normal operation
      ref_o <= 1'b0; // negative input reference
      trim_o <= OTC_TRIM_RST; // mid-scale trim
    end else if (wr_i) begin
      mode_o <= wdat_i[OTC_MODE_BIT];
      ref_o <= wdat_i[OTC_REF_BIT];
      trim_o <= wdat_i[OTC_TRIM_W-1:0];
    end
  end

  // read image of the register
  assign rdat_o = {1'b0, mode_o, ref_o, trim_o};
endmodule : otc_cmp_slot

`default_nettype wire

/* File: otc_offset_trim.sv */
// offset trim calibration register block with wishbone slave
// What this block does
// - per-comparator bit six selects calibration mode
// - per-comparator bit five selects reference input
// - five-bit read-write trim code in low bits
// - unimplemented bits ignore writes, read zero
// - hysteresis windows: comparator 1 bits 3:2, comparator 0 bits 1:0
// - amplifier output bit readable during calibration
// - comparator result bit readable during calibration
// - read-only result bit with polarity select
//
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module otc_offset_trim
  import otc_pkg::*;
(
  input wire logic clk_i, // system clock, 20 MHz
  input wire logic rst_i, // synchronous reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic cmp0_raw_i, // comparator 0 raw output
  input wire logic cmp1_raw_i, // comparator 1 raw output
  input wire logic amp_raw_i, // amplifier calibration output
  output logic cmp0_cal_mode_sel_o, // comparator 0 calibration mode
  output logic cmp0_cal_ref_sel_o, // comparator 0 reference select
  output logic [4:0] cmp0_trim_code_o, // comparator 0 trim code
  output logic cmp1_cal_mode_sel_o, // comparator 1 calibration mode
  output logic cmp1_cal_ref_sel_o, // comparator 1 reference select
  output logic [4:0] cmp1_trim_code_o, // comparator 1 trim code
  output logic [1:0] cmp0_hyst_window_o, // comparator 0 hysteresis window
  output logic [1:0] cmp1_hyst_window_o, // comparator 1 hysteresis window
  output logic cmp0_polarity_sel_o, // comparator 0 output polarity
  output logic cmp1_polarity_sel_o, // comparator 1 output polarity
  output logic amp_cal_mode_sel_o, // amplifier calibration mode
  output logic amp_cal_ref_sel_o, // amplifier reference select
  output logic [5:0] amp_trim_code_o // amplifier trim code
);
  otc_wb_st_t st_r; // bus handshake state
  logic req; // new request this cycle
  logic wr_lo; // write touching the low byte
  logic [3:0] hyst_r; // both hysteresis windows
  logic [1:0] pol_r; // polarity selects
  logic [1:0] res_r; // polarity-adjusted comparator results
  logic aout_r; // sampled amplifier output bit
  logic amode_r; // amplifier mode select
  logic aref_r; // amplifier reference select
  logic [5:0] atrim_r; // amplifier trim code
  logic [31:0] rdat_r; // registered read data
  logic [1:0] slot_mode; // mode bits from slots
  logic [1:0] slot_ref; // reference bits from slots
  logic [4:0] slot_trim [2]; // trim codes from slots
  logic [7:0] slot_rd [2]; // read images from slots
  logic [1:0] cmp_raw; // raw comparator inputs gathered
  logic [7:0] rd_byte; // selected read byte

  // a request is taken once, in the idle state
  assign req = wb_cyc_i && wb_stb_i && (st_r == OTC_IDLE);
  assign wr_lo = req && wb_we_i && wb_sel_i[0];
  assign cmp_raw = {cmp1_raw_i, cmp0_raw_i};

  // handshake: ack one cycle after a request, then back to idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= OTC_IDLE;
    end else begin
      unique case (st_r)
        OTC_IDLE: begin
          if (req) begin
            st_r <= OTC_ACK; // answer next cycle
          end
        end
        OTC_ACK: begin
          st_r <= OTC_IDLE; // ack stands one cycle
        end
        default: begin
          st_r <= OTC_IDLE; // recover from a broken code
        end
      endcase
    end
  end

  // comparator trim registers, one slot each
  generate
    for (genvar g = 0; g < 2; g++) begin : g_slot
      otc_cmp_slot u_slot (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(wr_lo && (wb_adr_i == (g == 0 ? OTC_CMP0_OFS : OTC_CMP1_OFS))),
        .wdat_i(wb_dat_i[7:0]),
        .mode_o(slot_mode[g]),
        .ref_o(slot_ref[g]),
        .trim_o(slot_trim[g]),
        .rdat_o(slot_rd[g])
      );
      // result bit follows the input, flipped by polarity
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          res_r[g] <= 1'b0;
        end else begin
          res_r[g] <= cmp_raw[g] ^ pol_r[g];
        end
      end
    end
  endgenerate

  // hysteresis windows; bits 7:4 have no storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hyst_r <= OTC_HYST_RST;
    end else if (wr_lo && wb_adr_i == OTC_HYST_OFS) begin
      hyst_r <= wb_dat_i[3:0];
    end
  end

  // polarity selects in the status register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pol_r <= 2'b00;
    end else if (wr_lo && wb_adr_i == OTC_STAT_OFS) begin
      pol_r <= {wb_dat_i[OTC_POL1_BIT], wb_dat_i[OTC_POL0_BIT]};
    end
  end

  // amplifier trim control; the search itself is run by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      amode_r <= 1'b0;
      aref_r <= 1'b0;
      atrim_r <= OTC_ATRIM_RST;
    end else if (wr_lo && wb_adr_i == OTC_AMP_OFS) begin
      amode_r <= wb_dat_i[OTC_AMODE_BIT];
      aref_r <= wb_dat_i[OTC_AREF_BIT];
      atrim_r <= wb_dat_i[OTC_ATRIM_W-1:0];
    end
  end

  // amplifier output bit sampled for software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aout_r <= 1'b0;
    end else begin
      aout_r <= amp_raw_i;
    end
  end

  // read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (wb_adr_i)
      OTC_CMP0_OFS: rd_byte = slot_rd[0];
      OTC_CMP1_OFS: rd_byte = slot_rd[1];
      OTC_HYST_OFS: rd_byte = {4'h0, hyst_r};
      OTC_STAT_OFS: rd_byte = {2'b00, pol_r, 1'b0, aout_r, res_r};
      OTC_AMP_OFS: rd_byte = {aref_r, amode_r, atrim_r};
      default: rd_byte = 8'h00;
    endcase
  end

  // read data latched when the request is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_r <= 32'h0000_0000;
    end else if (req) begin
      rdat_r <= {24'h00_0000, rd_byte};
    end
  end

  assign wb_dat_o = rdat_r;
  assign wb_ack_o = (st_r == OTC_ACK);
  assign cmp0_cal_mode_sel_o = slot_mode[0];
  assign cmp1_cal_mode_sel_o = slot_mode[1];
  assign cmp0_cal_ref_sel_o = slot_ref[0];
  assign cmp1_cal_ref_sel_o = slot_ref[1];
  assign cmp0_trim_code_o = slot_trim[0];
  assign cmp1_trim_code_o = slot_trim[1];
  assign cmp0_hyst_window_o = hyst_r[OTC_HYS0_LSB +: 2];
  assign cmp1_hyst_window_o = hyst_r[OTC_HYS1_LSB +: 2];
  assign cmp0_polarity_sel_o = pol_r[0];
  assign cmp1_polarity_sel_o = pol_r[1];
  assign amp_cal_mode_sel_o = amode_r;
  assign amp_cal_ref_sel_o = aref_r;
  assign amp_trim_code_o = atrim_r;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // a low-byte write to a given address
  sequence s_wr(logic [7:0] a);
    req && wb_we_i && wb_sel_i[0] && wb_adr_i == a;
  endsequence

  // a read of a given address
  sequence s_rd(logic [7:0] a);
    req && !wb_we_i && wb_adr_i == a;
  endsequence

  property p_ack_pulse;
    req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a single pulse");

  property p_mode_wr;
    s_wr(OTC_CMP0_OFS) |=> cmp0_cal_mode_sel_o == $past(wb_dat_i[OTC_MODE_BIT]);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode bit not loaded");

  property p_ref_wr;
    s_wr(OTC_CMP1_OFS) |=> cmp1_cal_ref_sel_o == $past(wb_dat_i[OTC_REF_BIT]);
  endproperty
  a_ref_wr: assert property (p_ref_wr) else $error("reference bit not loaded");

  property p_trim_rd;
    s_wr(OTC_CMP0_OFS) ##[2:8] s_rd(OTC_CMP0_OFS) |=>
      wb_ack_o && wb_dat_o[4:0] == cmp0_trim_code_o;
  endproperty
  a_trim_rd: assert property (p_trim_rd) else $error("trim readback wrong");

  property p_zero_bits;
    wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000
      && !($past(wb_adr_i) == OTC_CMP0_OFS && wb_dat_o[7])
      && !($past(wb_adr_i) == OTC_HYST_OFS && wb_dat_o[7:4] != 4'h0);
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused bits read nonzero");

  property p_hyst_wr;
    s_wr(OTC_HYST_OFS) |=> cmp1_hyst_window_o == $past(wb_dat_i[3:2])
      && cmp0_hyst_window_o == $past(wb_dat_i[1:0]);
  endproperty
  a_hyst_wr: assert property (p_hyst_wr) else $error("hysteresis fields misplaced");

  property p_aout;
    !rst_i |=> aout_r == $past(amp_raw_i);
  endproperty
  a_aout: assert property (p_aout) else $error("amplifier bit not sampled");

  property p_res;
    !rst_i |=> res_r == ($past(cmp_raw) ^ $past(pol_r));
  endproperty
  a_res: assert property (p_res) else $error("comparator result polarity wrong");

  property p_rst_val;
    @(posedge clk_i) disable iff (1'b0)
      rst_i |=> cmp0_trim_code_o == OTC_TRIM_RST && !cmp0_cal_mode_sel_o
      && !cmp1_cal_ref_sel_o && hyst_r == OTC_HYST_RST;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("reset values wrong");
endmodule : otc_offset_trim

`default_nettype wire

/* File: otc_analog_model.sv */
// stand-in for the two comparators and the amplifier behind the trim block
`timescale 1ns/1ps
`default_nettype none
module otc_analog_model (
  input wire logic c0_mode_i, // comparator 0 calibration mode
  input wire logic [4:0] c0_trim_i, // comparator 0 trim code
  input wire logic [4:0] c0_thr_i, // comparator 0 offset point
  input wire logic c0_lvl_i, // comparator 0 result in normal use
  input wire logic c1_mode_i, // comparator 1 calibration mode
  input wire logic [4:0] c1_trim_i, // comparator 1 trim code
  input wire logic [4:0] c1_thr_i, // comparator 1 offset point
  input wire logic c1_lvl_i, // comparator 1 result in normal use
  input wire logic a_mode_i, // amplifier calibration mode
  input wire logic [5:0] a_trim_i, // amplifier trim code
  input wire logic [5:0] a_thr_i, // amplifier offset point
  input wire logic a_lvl_i, // amplifier output in normal use
  output logic c0_raw_o, // comparator 0 raw output
  output logic c1_raw_o, // comparator 1 raw output
  output logic a_raw_o // amplifier raw output
);
  // comparators read high below the offset point, low from it on
  assign c0_raw_o = c0_mode_i ? (c0_trim_i < c0_thr_i) : c0_lvl_i;
  assign c1_raw_o = c1_mode_i ? (c1_trim_i < c1_thr_i) : c1_lvl_i;
  // amplifier reads low below the offset point, high from it on
  assign a_raw_o = a_mode_i ? (a_trim_i >= a_thr_i) : a_lvl_i;
endmodule : otc_analog_model
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the offset trim register block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import otc_pkg::*;
  logic clk_i = 1'b0; // system clock
  logic rst_i = 1'b1; // reset
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // bus request
  logic [7:0] adr = 8'h00; // bus address
  logic [3:0] sel = 4'hf; // byte selects
  logic [3:0] bsel = 4'hf; // byte selects for the next request
  logic [31:0] wdat = 32'h0; // write data
  logic [31:0] rdat; // read data
  logic ack, c0_raw, c1_raw, a_raw, c0_mode, c0_ref, c1_mode, c1_ref, a_mode, a_ref, pol0, pol1;
  logic [4:0] c0_trim, c1_trim; // comparator trims
  logic [1:0] h0, h1; // hysteresis windows
  logic [5:0] a_trim; // amplifier trim
  logic [5:0] thr [3] = '{6'h01, 6'h01, 6'h01}; // offset points
  logic [2:0] lvl = 3'h0; // normal-use analog results
  logic [7:0] sh [3] = '{8'h10, 8'h10, 8'h00}; // register shadows
  logic [7:0] d, a; // scratch
  logic [31:0] q; // scratch read
  int wd [3] = '{5, 5, 6}; // trim widths
  logic [7:0] ofs [3] = '{OTC_CMP0_OFS, OTC_CMP1_OFS, OTC_AMP_OFS}; // trim offsets
  logic [7:0] rbm [3] = '{8'h20, 8'h20, 8'h80}; // reference select masks
  int j, t, v, bad_count = 0, checks = 0;
  otc_offset_trim otc_offset_trim_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .cmp0_raw_i(c0_raw), .cmp1_raw_i(c1_raw),
    .amp_raw_i(a_raw), .cmp0_cal_mode_sel_o(c0_mode), .cmp0_cal_ref_sel_o(c0_ref),
    .cmp0_trim_code_o(c0_trim), .cmp1_cal_mode_sel_o(c1_mode), .cmp1_cal_ref_sel_o(c1_ref),
    .cmp1_trim_code_o(c1_trim), .cmp0_hyst_window_o(h0), .cmp1_hyst_window_o(h1),
    .cmp0_polarity_sel_o(pol0), .cmp1_polarity_sel_o(pol1), .amp_cal_mode_sel_o(a_mode),
    .amp_cal_ref_sel_o(a_ref), .amp_trim_code_o(a_trim));
  otc_analog_model otc_analog_model_i (.c0_mode_i(c0_mode), .c0_trim_i(c0_trim),
    .c0_thr_i(thr[0][4:0]), .c0_lvl_i(lvl[0]), .c1_mode_i(c1_mode), .c1_trim_i(c1_trim),
    .c1_thr_i(thr[1][4:0]), .c1_lvl_i(lvl[1]), .a_mode_i(a_mode), .a_trim_i(a_trim),
    .a_thr_i(thr[2]), .a_lvl_i(lvl[2]), .c0_raw_o(c0_raw), .c1_raw_o(c1_raw), .a_raw_o(a_raw));
  // free-running system clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // verdict and end of run
  task automatic stop_test;
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  // compare seen against expected
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one classic bus cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] dt, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= bsel;
    adr <= ad;
    wdat <= {24'h0, dt};
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk_i);
    if (n == 20) begin
      bad_count++;
      stop_test();
    end else begin
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
    end
  endtask : wb
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    logic [31:0] r;
    wb(1'b1, ad, dt, r);
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    logic [31:0] r;
    wb(1'b0, ad, 8'h00, r);
    chk(r, {24'h0, e});
  endtask : rd
  // load a code, let it settle, sample the result bit
  task automatic step(input int c, output logic s);
    logic [31:0] r;
    wr(ofs[j], 8'h40 | rbm[j] | 8'(c));
    repeat (4) @(posedge clk_i);
    wb(1'b0, OTC_STAT_OFS, 8'h00, r);
    s = r[j];
  endtask : step
  // rising then falling search, then restore the floored half sum
  task automatic cal(output int res);
    logic s0, s;
    int c, v1, top;
    top = (1 << wd[j]) - 1;
    wr(ofs[j], 8'h40);
    wr(ofs[j], 8'h40 | rbm[j]);
    for (int dir = 0; dir < 2; dir++) begin
      c = dir ? top : 0;
      step(c, s0);
      do begin
        c = dir ? c - 1 : c + 1;
        step(c, s);
      end while (s == s0 && c > 0 && c < top);
      if (dir == 0) v1 = c;
    end
    res = (v1 + c) / 2;
    wr(ofs[j], 8'(res));
  endtask : cal
  // expected restored code for an offset point
  function automatic int exp_cal(input int tp);
    return (tp + tp - 1) / 2;
  endfunction : exp_cal
  // watchdog on the whole run
  initial begin
    repeat (90000) @(posedge clk_i);
    bad_count++;
    stop_test();
  end
  // main sequence
  initial begin
    void'($urandom(65647));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OTC_CMP0_OFS, 8'h10);
    rd(OTC_CMP1_OFS, 8'h10);
    rd(OTC_HYST_OFS, 8'h00);
    rd(OTC_AMP_OFS, 8'h20);
    // random and all-ones writes, masked readback and port levels
    for (int i = 0; i < 15; i++) begin
      d = (i < 3) ? 8'hff : 8'($urandom);
      sh[i % 3] = d & ((i % 3 == 2) ? 8'h0f : 8'h7f);
      a = (i % 3 == 2) ? OTC_HYST_OFS : ofs[i % 3];
      wr(a, d);
      rd(a, sh[i % 3]);
      chk({c0_mode, c0_ref, c0_trim, c1_mode, c1_ref, c1_trim, h1, h0},
        {sh[0][6:0], sh[1][6:0], sh[2][3:0]});
    end
    // unmapped place and a write with the low select off
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    bsel = 4'he;
    wr(OTC_HYST_OFS, ~sh[2]);
    bsel = 4'hf;
    rd(OTC_HYST_OFS, sh[2]);
    // calibration of each cell at low, high and random offset points
    for (int k = 0; k < 9; k++) begin
      j = k % 3;
      t = (k < 3) ? 1 : (k < 6) ? (1 << wd[j]) - 1 : $urandom_range((1 << wd[j]) - 1, 1);
      thr[j] <= 6'(t);
      cal(v);
      chk(v, exp_cal(t));
      q = (j == 0) ? {c0_mode, 1'b0, c0_trim} : (j == 1) ? {c1_mode, 1'b0, c1_trim} : {a_mode, a_trim};
      chk(q, exp_cal(t));
    end
    // result bits follow the analog level and the polarity selects
    for (int i = 0; i < 6; i++) begin
      lvl <= 3'($urandom);
      d = (8'($urandom) & 8'hcf) | {2'b00, 2'(i), 4'h0};
      wr(OTC_STAT_OFS, d);
      rd(OTC_STAT_OFS, {2'b00, d[5:4], 1'b0, lvl[2], lvl[1] ^ d[5], lvl[0] ^ d[4]});
      chk({pol1, pol0}, d[5:4]);
    end
    // amplifier control byte: every bit stored and read back
    d = 8'($urandom);
    wr(OTC_AMP_OFS, d);
    rd(OTC_AMP_OFS, d);
    chk({a_ref, a_mode, a_trim}, d);
    // reset in mid-run brings every register back
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OTC_CMP1_OFS, 8'h10);
    rd(OTC_HYST_OFS, 8'h00);
    rd(OTC_AMP_OFS, 8'h20);
    chk({pol1, pol0, c0_mode, c0_ref, c0_trim}, {4'h0, OTC_TRIM_RST});
    stop_test();
  end
endmodule : tb
`default_nettype wire
